// *** common/sccc_pkg.sv ***
// Overview of operation
// - Skip-if-set discards the fetched next instruction when the tested file bit is one.
// - Skip-if-set takes two cycles on skip, one otherwise; a skip sets the skipped status bit, other flags keep.
// - Call via accumulator pushes program counter plus one onto the stack top.
// - Call loads PC[9:8] from table pointer, PC[7:0] from accumulator; two cycles, no flags.
// - Clear accumulator writes zero and sets the zero flag in one cycle.
// - Clear watchdog zeroes counter, and prescaler only when assigned to it; one cycle.
// - Clear watchdog sets both active-low timeout and power-down flags to one.
// - Clear register writes zero to the file register and sets zero flag, one cycle.
// - Complement register inverts the file register contents, touching only zero flag, one cycle.
// - Complement result goes to accumulator when destination is 0, file register when 1.
package sccc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_INSTR     = 8'h00;
  localparam logic [7:0] OFF_ACC       = 8'h04;
  localparam logic [7:0] OFF_TABLE_HI  = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0C;
  localparam logic [7:0] OFF_PC        = 8'h10;
  localparam logic [7:0] OFF_FADDR     = 8'h14;
  localparam logic [7:0] OFF_FDATA     = 8'h18;
  localparam logic [7:0] OFF_WDT_CFG   = 8'h1C;
  localparam logic [7:0] OFF_WDT_VAL   = 8'h20;
  localparam logic [7:0] OFF_STACK_TOP = 8'h24;

  // Instruction word fields
  localparam int OP_LSB    = 0;
  localparam int OP_MSB    = 2;
  localparam int ADDR_LSB  = 3;
  localparam int ADDR_MSB  = 8;
  localparam int BIT_LSB   = 9;
  localparam int BIT_MSB   = 11;
  localparam int DEST_POS  = 12;

  // Status register fields
  localparam int ST_ZERO    = 0;
  localparam int ST_TO_N    = 1;
  localparam int ST_PD_N    = 2;
  localparam int ST_SKIPPED = 3;
  localparam int ST_BUSY    = 4;
  localparam int ST_SP_LSB  = 8;
  localparam int ST_SLEEP   = 2;

  // Watchdog configuration fields
  localparam int WCFG_ASSIGN = 0;
  localparam int WCFG_ENABLE = 1;

  // Widths and sizes
  localparam int FILE_DEPTH  = 64;
  localparam int STACK_DEPTH = 8;
  localparam int PC_W        = 10;
  localparam int SP_W        = 3;

  // Reset values
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [1:0]  TABLE_HI_RST = 2'h0;
  localparam logic [9:0]  PC_RST   = 10'h000;
  localparam logic [1:0]  WCFG_RST = 2'h0;
  localparam logic [7:0]  CLEARED  = 8'h00;
  localparam logic [7:0]  ALL_ONES = 8'hFF;

  typedef enum logic [2:0]
  {
    OP_NOP    = 3'h0,
    OP_BTSS   = 3'h1,
    OP_CALL_IND    = 3'h2,
    OP_CLEAR_ACCUM = 3'h3,
    OP_CLEAR_WD    = 3'h4,
    OP_CLEAR_REG   = 3'h5,
    OP_COMPLEMENT  = 3'h6
  } sccc_op_type;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b001,
    ST_EXEC   = 3'b010,
    ST_SECOND = 3'b100
  } sccc_state_type;

endpackage

// *** rtl/sccc_call_stack.sv ***
module sccc_call_stack
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       push,
  input  wire logic [9:0] push_data,
  output logic      [2:0] sp,
  output logic      [9:0] top
);

  logic [9:0] mem [sccc_pkg::STACK_DEPTH];
  wire  [2:0] top_idx = sp - 3'h1;

  // Depth is fixed; a push past the top wraps and overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < sccc_pkg::STACK_DEPTH; i++)
        mem[i] <= sccc_pkg::PC_RST;
      sp <= 3'h0;
    end
    else if (push)
    begin
      mem[sp] <= push_data;
      sp      <= sp + 3'h1;
    end
  end

  assign top = mem[top_idx];

endmodule // sccc_call_stack

// *** rtl/sccc_exec_core.sv ***
// Design decisions made here: the address map and register access over APB.
module sccc_exec_core
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  sccc_pkg::sccc_state_type state;
  sccc_pkg::sccc_state_type next_state;
  logic [12:0] instr;
  logic [7:0]  acc;
  logic [1:0]  table_high_pointer;
  logic [9:0]  pc;
  logic        zero_flag;
  logic        timeout_flag_n;
  logic        powerdown_flag_n;
  logic        skipped;
  logic [5:0]  file_addr;
  logic [1:0]  wdt_cfg;
  logic [7:0]  watchdog_counter;
  logic [7:0]  shared_prescaler;
  logic        rd_fresh;
  logic [2:0]  sp;
  logic [9:0]  stack_top;
  logic [7:0]  file_rd;
  logic [7:0]  file_apb_rd;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  wire       busy       = (state != sccc_pkg::ST_IDLE);
  wire [2:0] op         = instr[sccc_pkg::OP_MSB:sccc_pkg::OP_LSB];
  wire [5:0] reg_addr   = instr[sccc_pkg::ADDR_MSB:sccc_pkg::ADDR_LSB];
  wire [2:0] bit_sel    = instr[sccc_pkg::BIT_MSB:sccc_pkg::BIT_LSB];
  wire       dest       = instr[sccc_pkg::DEST_POS];
  wire       in_exec    = (state == sccc_pkg::ST_EXEC);
  wire       in_second  = (state == sccc_pkg::ST_SECOND);
  wire       is_btss    = (op == sccc_pkg::OP_BTSS);
  wire       is_call        = (op == sccc_pkg::OP_CALL_IND);
  wire       is_clear_accum = (op == sccc_pkg::OP_CLEAR_ACCUM);
  wire       is_clear_wd    = (op == sccc_pkg::OP_CLEAR_WD);
  wire       is_clear_reg   = (op == sccc_pkg::OP_CLEAR_REG);
  wire       is_compl       = (op == sccc_pkg::OP_COMPLEMENT);
  wire       tested_bit = file_rd[bit_sel];
  wire [7:0] comp       = ~file_rd;
  wire [9:0] pc_next    = pc + 10'h001;

  // Writes stall during execution so software never races the core
  wire apb_access = psel && penable;
  assign pready   = apb_access && rd_fresh && !busy;
  wire apb_wr     = pready && pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire wr_instr  = apb_wr && hit(paddr, sccc_pkg::OFF_INSTR);
  wire wr_acc    = apb_wr && hit(paddr, sccc_pkg::OFF_ACC);
  wire wr_table_hi = apb_wr && hit(paddr, sccc_pkg::OFF_TABLE_HI);
  wire wr_status = apb_wr && hit(paddr, sccc_pkg::OFF_STATUS);
  wire wr_pc     = apb_wr && hit(paddr, sccc_pkg::OFF_PC);
  wire wr_faddr  = apb_wr && hit(paddr, sccc_pkg::OFF_FADDR);
  wire wr_fdata  = apb_wr && hit(paddr, sccc_pkg::OFF_FDATA);
  wire wr_wcfg   = apb_wr && hit(paddr, sccc_pkg::OFF_WDT_CFG);

  wire mapped = hit(paddr, sccc_pkg::OFF_INSTR) || hit(paddr, sccc_pkg::OFF_ACC)
             || hit(paddr, sccc_pkg::OFF_TABLE_HI) || hit(paddr, sccc_pkg::OFF_STATUS)
             || hit(paddr, sccc_pkg::OFF_PC) || hit(paddr, sccc_pkg::OFF_FADDR)
             || hit(paddr, sccc_pkg::OFF_FDATA) || hit(paddr, sccc_pkg::OFF_WDT_CFG)
             || hit(paddr, sccc_pkg::OFF_WDT_VAL) || hit(paddr, sccc_pkg::OFF_STACK_TOP);
  assign pslverr = pready && !mapped;

  wire [31:0] status_word = {21'h0, sp, 3'h0, busy, skipped, powerdown_flag_n, timeout_flag_n, zero_flag};

  wire [31:0] read_mux =
      hit(paddr, sccc_pkg::OFF_INSTR)     ? {19'h0, instr} :
      hit(paddr, sccc_pkg::OFF_ACC)       ? {24'h0, acc} :
      hit(paddr, sccc_pkg::OFF_TABLE_HI)  ? {30'h0, table_high_pointer} :
      hit(paddr, sccc_pkg::OFF_STATUS)    ? status_word :
      hit(paddr, sccc_pkg::OFF_PC)        ? {22'h0, pc} :
      hit(paddr, sccc_pkg::OFF_FADDR)     ? {26'h0, file_addr} :
      hit(paddr, sccc_pkg::OFF_FDATA)     ? {24'h0, file_apb_rd} :
      hit(paddr, sccc_pkg::OFF_WDT_CFG)   ? {30'h0, wdt_cfg} :
      hit(paddr, sccc_pkg::OFF_WDT_VAL)   ? {16'h0, shared_prescaler, watchdog_counter} :
      hit(paddr, sccc_pkg::OFF_STACK_TOP) ? {22'h0, stack_top} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // File register port

  wire       exec_fwr   = in_exec && (is_clear_reg || (is_compl && dest));
  wire [7:0] exec_fdata = is_compl ? comp : sccc_pkg::CLEARED;
  wire       f_we       = exec_fwr || wr_fdata;
  wire [5:0] f_waddr    = exec_fwr ? reg_addr : file_addr;
  wire [7:0] f_wdata    = exec_fwr ? exec_fdata : pwdata[7:0];

  sccc_file_regs u_file
  (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (f_we),
    .waddr   (f_waddr),
    .wdata   (f_wdata),
    .raddr_a (reg_addr),
    .rdata_a (file_rd),
    .raddr_b (file_addr),
    .rdata_b (file_apb_rd)
  );

  wire push = in_exec && is_call;

  sccc_call_stack u_stack
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (push),
    .push_data (pc_next),
    .sp        (sp),
    .top       (stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    next_state = state;
    case (state)
      sccc_pkg::ST_IDLE:
        if (wr_instr)
          next_state = sccc_pkg::ST_EXEC;
      sccc_pkg::ST_EXEC:
        if ((is_btss && tested_bit) || is_call)
          next_state = sccc_pkg::ST_SECOND;
        else
          next_state = sccc_pkg::ST_IDLE;
      sccc_pkg::ST_SECOND:
        next_state = sccc_pkg::ST_IDLE;
      default:
        next_state = sccc_pkg::ST_IDLE;
    endcase
  end

  wire [9:0] call_target = {table_high_pointer, acc};

  wire [9:0] next_pc = wr_pc                   ? pwdata[9:0] :
                       (in_second && is_call)  ? call_target :
                       (in_exec && !is_call)   ? pc_next :
                       in_second               ? pc_next : pc;

  wire next_zero = (in_exec && (is_clear_accum || is_clear_reg)) ? 1'b1 :
                   (in_exec && is_compl)                         ? (comp == sccc_pkg::CLEARED) : zero_flag;

  wire [7:0] next_acc = wr_acc                           ? pwdata[7:0] :
                        (in_exec && is_clear_accum)      ? sccc_pkg::CLEARED :
                        (in_exec && is_compl && !dest)   ? comp : acc;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= sccc_pkg::ST_IDLE;
      instr     <= 13'h0000;
      acc       <= sccc_pkg::ACC_RST;
      table_high_pointer <= sccc_pkg::TABLE_HI_RST;
      pc        <= sccc_pkg::PC_RST;
      zero_flag <= 1'b0;
      skipped   <= 1'b0;
      file_addr <= 6'h00;
      wdt_cfg   <= sccc_pkg::WCFG_RST;
      rd_fresh  <= 1'b0;
      prdata    <= 32'h0000_0000;
    end
    else
    begin
      state     <= next_state;
      pc        <= next_pc;
      acc       <= next_acc;
      zero_flag <= next_zero;
      rd_fresh  <= psel && !busy;
      prdata    <= read_mux;
      if (wr_instr)
        instr <= pwdata[12:0];
      if (wr_table_hi)
        table_high_pointer <= pwdata[1:0];
      if (wr_faddr)
        file_addr <= pwdata[5:0];
      if (wr_wcfg)
        wdt_cfg <= pwdata[1:0];
      if (wr_instr)
        skipped <= 1'b0;
      else if (in_second && is_btss)
        skipped <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog

  wire clear_wd    = in_exec && is_clear_wd;
  wire wd_assigned = wdt_cfg[sccc_pkg::WCFG_ASSIGN];
  wire wd_enable   = wdt_cfg[sccc_pkg::WCFG_ENABLE];
  wire wd_tick     = wd_enable && (!wd_assigned || (shared_prescaler == sccc_pkg::ALL_ONES));
  wire timeout     = wd_tick && (watchdog_counter == sccc_pkg::ALL_ONES) && !clear_wd;
  wire sleep_req   = wr_status && pwdata[sccc_pkg::ST_SLEEP];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_counter <= sccc_pkg::CLEARED;
      shared_prescaler <= sccc_pkg::CLEARED;
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end
    else
    begin
      if (clear_wd)
        watchdog_counter <= sccc_pkg::CLEARED;
      else if (wd_tick)
        watchdog_counter <= watchdog_counter + 8'h01;
      if (clear_wd && wd_assigned)
        shared_prescaler <= sccc_pkg::CLEARED;
      else
        shared_prescaler <= shared_prescaler + 8'h01;
      if (timeout)
        timeout_flag_n <= 1'b0;
      else if (clear_wd)
        timeout_flag_n <= 1'b1;
      if (sleep_req)
        powerdown_flag_n <= 1'b0;
      else if (clear_wd)
        powerdown_flag_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_skip_two;
    in_exec && is_btss && tested_bit |=> in_second ##1 !busy && pc == $past(pc, 2) + 10'h002;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

  property p_noskip_one;
    in_exec && is_btss && !tested_bit |=> !busy && $stable(zero_flag) && $stable(timeout_flag_n);
  endproperty
  a_noskip_one: assert property (p_noskip_one) else $error("no-skip not one cycle");

  property p_call_push;
    in_exec && is_call |=> stack_top == $past(pc) + 10'h001;
  endproperty
  a_call_push: assert property (p_call_push) else $error("wrong return address");

  property p_call_jump;
    in_exec && is_call |=> in_second ##1 !busy && pc == {$past(table_high_pointer, 2), $past(acc, 2)}
      && $stable(zero_flag);
  endproperty
  a_call_jump: assert property (p_call_jump) else $error("wrong call target");

  property p_clear_accum;
    in_exec && is_clear_accum |=> acc == 8'h00 && zero_flag && !busy;
  endproperty
  a_clear_accum: assert property (p_clear_accum) else $error("accumulator not cleared");

  property p_clear_wd;
    in_exec && is_clear_wd |=> watchdog_counter == 8'h00 && (!wd_assigned || shared_prescaler == 8'h00);
  endproperty
  a_clear_wd: assert property (p_clear_wd) else $error("watchdog not cleared");

  property p_flags;
    in_exec && is_clear_wd && !sleep_req |=> powerdown_flag_n && timeout_flag_n;
  endproperty
  a_flags: assert property (p_flags) else $error("status flags not set");

  property p_clear_reg;
    in_exec && is_clear_reg |=> file_rd == 8'h00 && zero_flag;
  endproperty
  a_clear_reg: assert property (p_clear_reg) else $error("register not cleared");

  property p_compl_dest;
    in_exec && is_compl |=> (dest ? file_rd == ~$past(file_rd) : acc == ~$past(file_rd)) && !busy;
  endproperty
  a_compl_dest: assert property (p_compl_dest) else $error("complement misrouted");

  property p_compl_zero;
    in_exec && is_compl |=> zero_flag == ($past(file_rd) == 8'hFF);
  endproperty
  a_compl_zero: assert property (p_compl_zero) else $error("zero flag wrong");

  property p_sp_inc;
    in_exec && is_call |=> sp == $past(sp) + 3'h1;
  endproperty
  a_sp_inc: assert property (p_sp_inc) else $error("stack pointer not advanced");

endmodule // sccc_exec_core

// *** rtl/sccc_file_regs.sv ***
module sccc_file_regs
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] raddr_a,
  output logic      [7:0] rdata_a,
  input  wire logic [5:0] raddr_b,
  output logic      [7:0] rdata_b
);

  logic [7:0] mem [sccc_pkg::FILE_DEPTH];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < sccc_pkg::FILE_DEPTH; i++)
        mem[i] <= sccc_pkg::CLEARED;
    end
    else if (we)
      mem[waddr] <= wdata;
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule // sccc_file_regs

// *** sim/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err_seen;
  logic [7:0]  pat;
  int          n_fail;
  int          check_count;
  int          cycles;
  int          wait_n;
  int          w_base;
  int          pc_exp;

  sccc_exec_core i_dut
  (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      $display("MISMATCH at %0t: timeout", $time);
      test_done();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Answer taken at the rising edge that samples pready high; only the hang guard ends a wait
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    wait_n   = n;
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task exec(input sccc_pkg::sccc_op_type op, input logic [5:0] a, input logic [2:0] b, input logic d);
    wr(sccc_pkg::OFF_INSTR, {19'h0, d, b, a, op});
  endtask

  // Status read right after an instruction; its wait shows the op length
  task st_chk(input logic [3:0] mask, input logic [3:0] exp, input int extra);
    xfer(1'b0, sccc_pkg::OFF_STATUS, 32'h0);
    check({28'h0, rd[3:0] & mask}, {28'h0, exp});
    check(32'(wait_n), 32'(w_base + extra));
  endtask

  task do_call(input logic [7:0] acc, input logic [1:0] hp, input logic [9:0] pc0, input logic [2:0] sp);
    wr(sccc_pkg::OFF_ACC, {24'h0, acc});
    wr(sccc_pkg::OFF_TABLE_HI, {30'h0, hp});
    wr(sccc_pkg::OFF_PC, {22'h0, pc0});
    exec(sccc_pkg::OP_CALL_IND, 6'h0, 3'h0, 1'b0);
    st_chk(4'h7, 4'h7, 1);
    check({29'h0, rd[10:8]}, {29'h0, sp});
    rd_chk(sccc_pkg::OFF_PC, {22'h0, hp, acc});
    rd_chk(sccc_pkg::OFF_STACK_TOP, {22'h0, pc0 + 10'h001});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    w_base = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(sccc_pkg::OFF_ACC, 32'h0);
    rd_chk(sccc_pkg::OFF_STATUS, 32'h0000_0006);
    xfer(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err_seen}, 32'h1);
    $display("test reset done");

    wr(sccc_pkg::OFF_ACC, 32'h0000_0055);
    exec(sccc_pkg::OP_CLEAR_ACCUM, 6'h0, 3'h0, 1'b0);
    xfer(1'b0, sccc_pkg::OFF_STATUS, 32'h0);
    w_base = wait_n;
    check({31'h0, rd[0]}, 32'h1);
    rd_chk(sccc_pkg::OFF_ACC, 32'h0);
    $display("test clear_accumulator done");

    do_call(8'h34, 2'h2, 10'h0A0, 3'h1);
    do_call(8'hFF, 2'h3, 10'h3FE, 3'h2);
    $display("test call done");

    // Each bit of the pattern decides skip or not; zero flag stays set
    pat = 8'h5A;
    pc_exp = 0;
    wr(sccc_pkg::OFF_FADDR, 32'h0000_003F);
    wr(sccc_pkg::OFF_FDATA, {24'h0, pat});
    wr(sccc_pkg::OFF_PC, 32'h0);
    for (int b = 0; b < 8; b++)
    begin
      exec(sccc_pkg::OP_BTSS, 6'h3F, 3'(b), 1'b0);
      pc_exp += 1 + int'(pat[b]);
      st_chk(4'hF, {pat[b], 3'h7}, int'(pat[b]));
    end
    rd_chk(sccc_pkg::OFF_PC, 32'(pc_exp));
    $display("test skip done");

    wr(sccc_pkg::OFF_FADDR, 32'h0000_000B);
    wr(sccc_pkg::OFF_FDATA, 32'h0000_00FF);
    exec(sccc_pkg::OP_COMPLEMENT, 6'h0B, 3'h0, 1'b0);
    st_chk(4'h7, 4'h7, 0);
    rd_chk(sccc_pkg::OFF_ACC, 32'h0);
    rd_chk(sccc_pkg::OFF_FDATA, 32'h0000_00FF);
    wr(sccc_pkg::OFF_FADDR, 32'h0000_000A);
    wr(sccc_pkg::OFF_FDATA, 32'h0000_00A6);
    exec(sccc_pkg::OP_COMPLEMENT, 6'h0A, 3'h0, 1'b1);
    st_chk(4'h7, 4'h6, 0);
    rd_chk(sccc_pkg::OFF_FDATA, 32'h0000_0059);
    rd_chk(sccc_pkg::OFF_ACC, 32'h0);
    $display("test complement done");

    wr(sccc_pkg::OFF_FADDR, 32'h0);
    wr(sccc_pkg::OFF_FDATA, 32'h0000_0055);
    exec(sccc_pkg::OP_CLEAR_REG, 6'h00, 3'h0, 1'b0);
    st_chk(4'h1, 4'h1, 0);
    rd_chk(sccc_pkg::OFF_FDATA, 32'h0);
    $display("test clear_register done");

    // Unassigned counter ticks every cycle, so 300 cycles force a timeout
    wr(sccc_pkg::OFF_WDT_CFG, 32'h0000_0002);
    repeat (300) @(posedge pclk);
    xfer(1'b0, sccc_pkg::OFF_STATUS, 32'h0);
    check({31'h0, rd[1]}, 32'h0);
    wr(sccc_pkg::OFF_STATUS, 32'h0000_0004);
    xfer(1'b0, sccc_pkg::OFF_STATUS, 32'h0);
    check({31'h0, rd[2]}, 32'h0);
    wr(sccc_pkg::OFF_WDT_CFG, 32'h0000_0003);
    exec(sccc_pkg::OP_CLEAR_WD, 6'h0, 3'h0, 1'b0);
    st_chk(4'h6, 4'h6, 0);
    xfer(1'b0, sccc_pkg::OFF_WDT_VAL, 32'h0);
    check({24'h0, rd[7:0]}, 32'h0);
    check({31'h0, rd[15:8] < 8'h10}, 32'h1);
    $display("test clear_watchdog done");
    test_done();
  end

endmodule // tb
